/* core/fault_sleep_ctrl.sv */
// Fault escalation, lockup and sleep control with a Wishbone register port
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module fault_sleep_ctrl (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire fault_sleep_pkg::fault_t fault_i,
  input wire fault_sleep_pkg::exec_ctx_t ctx_i,
  input wire logic [1:0] cur_prio_i,
  input wire logic unstack_psr_err_i,
  input wire logic unstack_main_sp_i,
  input wire logic nmi_i,
  input wire logic debug_halt_i,
  input wire fault_sleep_pkg::exc_req_t exc_i,
  input wire logic priority_mask_bit_i,
  input wire logic wait_interrupt_instr_i,
  input wire logic wait_event_instr_i,
  input wire logic return_to_thread_i,
  input wire logic new_pending_i,
  input wire logic ext_event_i,
  input wire logic peer_send_event_i,
  output logic severe_error_take_o,
  output logic exc_entry_o,
  output logic wfe_continue_o,
  output logic exec_halt_o,
  output logic locked_o,
  output logic sleeping_o,
  output logic deep_sleep_o,
  output logic standby_select_o
);
  fault_sleep_pkg::ctrl_state_t q;
  fault_sleep_pkg::ctrl_state_t d;

  logic fault_any;
  logic crit_ctx;
  logic [2:0] cur_level;
  logic higher;
  logic ev_now;
  logic bus_req;

  ////////////////////////////////////////////////////////////////////////////
  // Fault and priority decode

  always_comb begin
    fault_any = (fault_i.svc_exec & fault_i.svc_prio_blocked)
              | (fault_i.breakpoint_instr_exec & ~fault_i.debugger_attached)
              | fault_i.ldst_bus_err | fault_i.vector_bus_err
              | fault_i.fetch_xn | fault_i.fetch_bus_err
              | fault_i.undef_instr | fault_i.istate_zero | fault_i.unaligned
              | fault_i.mpu_priv | fault_i.mpu_unmanaged;
    crit_ctx = (ctx_i == fault_sleep_pkg::CTX_NMI) || (ctx_i == fault_sleep_pkg::CTX_SEVERE);
    cur_level = (ctx_i == fault_sleep_pkg::CTX_THREAD) ? fault_sleep_pkg::THREAD_PRIO
                                                        : {1'b0, cur_prio_i};
    // Configurable levels never beat NMI or severe handlers
    higher = exc_i.valid && exc_i.enabled && !crit_ctx && ({1'b0, exc_i.prio} < cur_level);
    // Pending interrupts become events when enabled by software
    ev_now = (q.ext_s2 & ~q.ext_s3) | (q.peer_s2 & ~q.peer_s3)
           | (q.ev_pend & new_pending_i);
    bus_req = wb_cyc_i && wb_stb_i && !q.ack;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.severe_take = 1'b0;
    d.exc_entry = 1'b0;
    d.wfe_cont = 1'b0;
    d.ack = bus_req;
    // Pins pass two flops before any logic; third flop for edge detect
    d.ext_s1 = ext_event_i;
    d.ext_s2 = q.ext_s1;
    d.ext_s3 = q.ext_s2;
    d.peer_s1 = peer_send_event_i;
    d.peer_s2 = q.peer_s1;
    d.peer_s3 = q.peer_s2;
    // Only hardware events set the latch
    if (ev_now && q.state != fault_sleep_pkg::ST_SLEEP_EVT) begin
      d.event_latch = 1'b1;
    end
    case (q.state)
      fault_sleep_pkg::ST_RUN: begin
        if (nmi_i) begin
          d.exc_entry = 1'b1;
        end else if (fault_any) begin
          if (crit_ctx) begin
            d.state = fault_sleep_pkg::ST_LOCKED;
            d.lock_nmi = (ctx_i == fault_sleep_pkg::CTX_NMI);
          end else begin
            d.severe_take = 1'b1;
          end
        end else if (unstack_psr_err_i && unstack_main_sp_i) begin
          d.state = fault_sleep_pkg::ST_LOCKED;
          d.lock_nmi = (ctx_i == fault_sleep_pkg::CTX_NMI);
        end else if (wait_interrupt_instr_i) begin
          d.state = fault_sleep_pkg::ST_SLEEP_INT;
          d.deep = q.deep_sel;
        end else if (return_to_thread_i && q.sleep_ret) begin
          d.state = fault_sleep_pkg::ST_SLEEP_INT;
          d.deep = q.deep_sel;
        end else if (wait_event_instr_i) begin
          // Event arriving now counts as a set latch
          if (q.event_latch || ev_now) begin
            d.event_latch = 1'b0;
            d.wfe_cont = 1'b1;
          end else begin
            d.state = fault_sleep_pkg::ST_SLEEP_EVT;
            d.deep = q.deep_sel;
          end
        end else if (higher && !priority_mask_bit_i) begin
          d.exc_entry = 1'b1;
        end
      end
      fault_sleep_pkg::ST_SLEEP_INT: begin
        // Mask does not block the wake itself
        if (higher || nmi_i) begin
          d.state = fault_sleep_pkg::ST_RUN;
        end
      end
      fault_sleep_pkg::ST_SLEEP_EVT: begin
        if (higher || nmi_i || ev_now) begin
          d.state = fault_sleep_pkg::ST_RUN;
        end
      end
      fault_sleep_pkg::ST_LOCKED: begin
        // Leave on debug halt or NMI
        // NMI ignored when locked from NMI handler
        if (debug_halt_i || (nmi_i && !q.lock_nmi)) begin
          d.state = fault_sleep_pkg::ST_RUN;
          d.exc_entry = nmi_i && !debug_halt_i;
        end
      end
      default: begin
        d.state = fault_sleep_pkg::ST_RUN;
      end
    endcase
    // Bus: single-cycle answer, unmapped reads zero, writes ignored
    d.rdata = 32'h0000_0000;
    if (bus_req) begin
      if (wb_adr_i == fault_sleep_pkg::SYS_CTRL_OFS) begin
        d.rdata[fault_sleep_pkg::SLEEP_RET_BIT] = q.sleep_ret;
        d.rdata[fault_sleep_pkg::DEEP_SEL_BIT] = q.deep_sel;
        d.rdata[fault_sleep_pkg::EV_PEND_BIT] = q.ev_pend;
        if (wb_we_i && wb_sel_i[0]) begin
          d.sleep_ret = wb_dat_i[fault_sleep_pkg::SLEEP_RET_BIT];
          d.deep_sel = wb_dat_i[fault_sleep_pkg::DEEP_SEL_BIT];
          d.ev_pend = wb_dat_i[fault_sleep_pkg::EV_PEND_BIT];
        end
      end else if (wb_adr_i == fault_sleep_pkg::PWR_CTRL_OFS) begin
        d.rdata[fault_sleep_pkg::PWR_DOWN_BIT] = q.pwr_down;
        if (wb_we_i && wb_sel_i[0]) begin
          d.pwr_down = wb_dat_i[fault_sleep_pkg::PWR_DOWN_BIT];
        end
      end else if (wb_adr_i == fault_sleep_pkg::STATUS_OFS) begin
        d.rdata[fault_sleep_pkg::ST_LOCKED_BIT] = (q.state == fault_sleep_pkg::ST_LOCKED);
        d.rdata[fault_sleep_pkg::ST_LOCK_NMI_BIT] = q.lock_nmi;
        d.rdata[fault_sleep_pkg::ST_SLEEP_BIT] = sleeping_o;
        d.rdata[fault_sleep_pkg::ST_DEEP_BIT] = deep_sleep_o;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
      q.state <= fault_sleep_pkg::ST_RUN;
      q.sleep_ret <= fault_sleep_pkg::SYS_CTRL_RST[fault_sleep_pkg::SLEEP_RET_BIT];
      q.deep_sel <= fault_sleep_pkg::SYS_CTRL_RST[fault_sleep_pkg::DEEP_SEL_BIT];
      q.ev_pend <= fault_sleep_pkg::SYS_CTRL_RST[fault_sleep_pkg::EV_PEND_BIT];
      q.pwr_down <= fault_sleep_pkg::PWR_CTRL_RST[fault_sleep_pkg::PWR_DOWN_BIT];
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    wb_ack_o = q.ack;
    wb_dat_o = q.rdata;
    severe_error_take_o = q.severe_take;
    exc_entry_o = q.exc_entry;
    wfe_continue_o = q.wfe_cont;
    exec_halt_o = (q.state != fault_sleep_pkg::ST_RUN);
    locked_o = (q.state == fault_sleep_pkg::ST_LOCKED);
    sleeping_o = (q.state == fault_sleep_pkg::ST_SLEEP_INT)
              || (q.state == fault_sleep_pkg::ST_SLEEP_EVT);
    deep_sleep_o = sleeping_o && q.deep;
    // Stop or standby in deep sleep
    standby_select_o = deep_sleep_o && q.pwr_down;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  a_fault_escalates: assert property (
    q.state == fault_sleep_pkg::ST_RUN && !nmi_i && fault_any && !crit_ctx
    |=> severe_error_take_o && !locked_o)
    else $error("fault outside critical handler did not take severe error");
  a_fault_locks: assert property (
    q.state == fault_sleep_pkg::ST_RUN && !nmi_i && fault_any && crit_ctx
    |=> locked_o && !severe_error_take_o)
    else $error("fault in critical handler did not lock");
  a_svc_fault: assert property (
    q.state == fault_sleep_pkg::ST_RUN && !nmi_i && !crit_ctx
    && fault_i.svc_exec && fault_i.svc_prio_blocked |=> severe_error_take_o)
    else $error("blocked supervisor call not faulted");
  a_unaligned_fault: assert property (
    q.state == fault_sleep_pkg::ST_RUN && !nmi_i && !crit_ctx && fault_i.unaligned
    |=> severe_error_take_o)
    else $error("unaligned access not faulted");
  a_severe_no_preempt: assert property (
    ctx_i == fault_sleep_pkg::CTX_SEVERE && !nmi_i |=> !exc_entry_o)
    else $error("configurable exception preempted severe handler");
  a_unstack_lock: assert property (
    q.state == fault_sleep_pkg::ST_RUN && !nmi_i && !fault_any
    && unstack_psr_err_i && unstack_main_sp_i |=> locked_o)
    else $error("unstack bus error did not lock");
  a_lock_holds: assert property (
    locked_o && !debug_halt_i && !nmi_i |=> locked_o && exec_halt_o)
    else $error("lockup left without cause");
  a_nmi_lock_stays: assert property (
    locked_o && q.lock_nmi && !debug_halt_i |=> locked_o)
    else $error("NMI released lockup from NMI handler");
  a_wfi_sleeps: assert property (
    q.state == fault_sleep_pkg::ST_RUN && wait_interrupt_instr_i && !nmi_i && !fault_any
    && !(unstack_psr_err_i && unstack_main_sp_i)
    |=> sleeping_o && (deep_sleep_o == $past(q.deep_sel)))
    else $error("wait-for-interrupt did not sleep at chosen level");
  a_wfe_latch_skip: assert property (
    q.state == fault_sleep_pkg::ST_RUN && wait_event_instr_i && q.event_latch
    && !nmi_i && !fault_any && !wait_interrupt_instr_i && !return_to_thread_i
    && !(unstack_psr_err_i && unstack_main_sp_i)
    |=> wfe_continue_o && !sleeping_o)
    else $error("set latch did not skip event-wait sleep");
  a_event_wakes: assert property (
    q.state == fault_sleep_pkg::ST_SLEEP_EVT && q.ext_s2 && !q.ext_s3 |=> !sleeping_o)
    else $error("external event did not wake event-wait sleep");
  a_masked_wake: assert property (
    q.state == fault_sleep_pkg::ST_SLEEP_INT && higher && priority_mask_bit_i
    |=> !sleeping_o ##1 !exc_entry_o || !priority_mask_bit_i)
    else $error("masked interrupt did not wake or ran handler");
  a_peer_wakes: assert property (
    q.state == fault_sleep_pkg::ST_SLEEP_EVT && q.peer_s2 && !q.peer_s3 |=> !sleeping_o)
    else $error("peer send-event did not wake event-wait sleep");
  a_pending_wakes: assert property (
    q.state == fault_sleep_pkg::ST_SLEEP_EVT && q.ev_pend && new_pending_i |=> !sleeping_o)
    else $error("new pending interrupt did not wake event-wait sleep");
  a_return_sleeps: assert property (
    q.state == fault_sleep_pkg::ST_RUN && return_to_thread_i && q.sleep_ret && !nmi_i
    && !fault_any && !(unstack_psr_err_i && unstack_main_sp_i) && !wait_interrupt_instr_i
    |=> sleeping_o)
    else $error("handler return did not sleep");
  a_wfi_no_event_wake: assert property (
    q.state == fault_sleep_pkg::ST_SLEEP_INT && !higher && !nmi_i |=> sleeping_o)
    else $error("interrupt-wait sleep ended without an exception");

  c_lock_release: cover property (locked_o ##1 !locked_o);
  c_wfe_wake: cover property (q.state == fault_sleep_pkg::ST_SLEEP_EVT ##1 !sleeping_o);
  c_deep_standby: cover property (standby_select_o);
  c_severe_take: cover property (severe_error_take_o);
endmodule : fault_sleep_ctrl
`default_nettype wire

/* shared/fault_sleep_pkg.sv */
// Constants and types for the fault, lockup and sleep controller
package fault_sleep_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] SYS_CTRL_OFS = 8'h00;
  localparam logic [7:0] PWR_CTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  // System control register fields
  localparam int SLEEP_RET_BIT = 1;
  localparam int DEEP_SEL_BIT = 2;
  localparam int EV_PEND_BIT = 4;
  // Power control register field
  localparam int PWR_DOWN_BIT = 1;
  // Status register fields
  localparam int ST_LOCKED_BIT = 0;
  localparam int ST_LOCK_NMI_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  localparam int ST_DEEP_BIT = 3;
  // Reset values
  localparam logic [31:0] SYS_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PWR_CTRL_RST = 32'h0000_0000;
  // Priority of thread code, below every configurable level
  localparam logic [2:0] THREAD_PRIO = 3'h4;

  typedef enum logic [1:0] {
    CTX_THREAD,
    CTX_HANDLER,
    CTX_NMI,
    CTX_SEVERE
  } exec_ctx_t;

  typedef enum {
    ST_RUN,
    ST_SLEEP_INT,
    ST_SLEEP_EVT,
    ST_LOCKED
  } run_state_t;

  typedef struct packed {
    logic svc_exec;
    logic svc_prio_blocked;
    logic breakpoint_instr_exec;
    logic debugger_attached;
    logic ldst_bus_err;
    logic vector_bus_err;
    logic fetch_xn;
    logic fetch_bus_err;
    logic undef_instr;
    logic istate_zero;
    logic unaligned;
    logic mpu_priv;
    logic mpu_unmanaged;
  } fault_t;

  typedef struct packed {
    logic valid;
    logic enabled;
    logic [1:0] prio;
  } exc_req_t;

  typedef struct packed {
    run_state_t state;
    logic lock_nmi;
    logic event_latch;
    logic deep;
    logic sleep_ret;
    logic deep_sel;
    logic ev_pend;
    logic pwr_down;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic peer_s1;
    logic peer_s2;
    logic peer_s3;
    logic severe_take;
    logic exc_entry;
    logic wfe_cont;
    logic ack;
    logic [31:0] rdata;
  } ctrl_state_t;
endpackage : fault_sleep_pkg

/* tb/event_source.sv */
// Model of the peripheral event line and the neighbour core's send-event line
`timescale 1ns/100ps
`default_nettype none
module event_source (
  input wire logic core_clk_i,
  output logic ext_event_o,
  output logic peer_event_o
);
  initial begin
    ext_event_o = 1'b0;
    peer_event_o = 1'b0;
  end
  // Held two cycles so the receiver's synchroniser sees a clean edge
  task send(input logic peer);
    @(posedge core_clk_i);
    ext_event_o <= !peer;
    peer_event_o <= peer;
    repeat (2) @(posedge core_clk_i);
    ext_event_o <= 1'b0;
    peer_event_o <= 1'b0;
  endtask : send
endmodule : event_source
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the fault, lockup and sleep controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int WAIT_INTERRUPT_INSTR = 0, WAIT_EVENT_INSTR = 1, RET = 2, NMI = 3, DBG = 4, NEWP = 5;
  logic core_clk_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  fault_sleep_pkg::fault_t fault_i;
  fault_sleep_pkg::exec_ctx_t ctx_i, ctx;
  fault_sleep_pkg::exc_req_t exc_i;
  logic [1:0] cur_prio_i;
  logic unstack_psr_err_i, unstack_main_sp_i, nmi_i, debug_halt_i, priority_mask_bit_i;
  logic wait_interrupt_instr_i, wait_event_instr_i, return_to_thread_i, new_pending_i;
  logic ext_event_i, peer_send_event_i, severe_error_take_o, exc_entry_o, wfe_continue_o;
  logic exec_halt_o, locked_o, sleeping_o, deep_sleep_o, standby_select_o, d, p;
  int bad_count, checked, k, seed;

  fault_sleep_ctrl uut (.core_clk_i(core_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fault_i(fault_i),
    .ctx_i(ctx_i), .cur_prio_i(cur_prio_i), .unstack_psr_err_i(unstack_psr_err_i),
    .unstack_main_sp_i(unstack_main_sp_i), .nmi_i(nmi_i), .debug_halt_i(debug_halt_i),
    .exc_i(exc_i), .priority_mask_bit_i(priority_mask_bit_i),
    .wait_interrupt_instr_i(wait_interrupt_instr_i), .wait_event_instr_i(wait_event_instr_i),
    .return_to_thread_i(return_to_thread_i), .new_pending_i(new_pending_i),
    .ext_event_i(ext_event_i), .peer_send_event_i(peer_send_event_i),
    .severe_error_take_o(severe_error_take_o), .exc_entry_o(exc_entry_o),
    .wfe_continue_o(wfe_continue_o), .exec_halt_o(exec_halt_o), .locked_o(locked_o),
    .sleeping_o(sleeping_o), .deep_sleep_o(deep_sleep_o),
    .standby_select_o(standby_select_o));
  event_source ev (.core_clk_i(core_clk_i), .ext_event_o(ext_event_i),
    .peer_event_o(peer_send_event_i));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    @(posedge core_clk_i iff wb_ack_o === 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // One-cycle strobe; outputs looked at once the taking edge has landed
  task fire(input int which);
    @(posedge core_clk_i);
    {new_pending_i, debug_halt_i, nmi_i, return_to_thread_i, wait_event_instr_i,
      wait_interrupt_instr_i} <= 6'h1 << which;
    @(posedge core_clk_i);
    {new_pending_i, debug_halt_i, nmi_i, return_to_thread_i, wait_event_instr_i,
      wait_interrupt_instr_i} <= 6'h0;
    @(negedge core_clk_i);
  endtask : fire
  task raise_exc(input logic [1:0] prio, input logic go);
    @(posedge core_clk_i);
    exc_i <= '{valid: go, enabled: 1'b1, prio: prio};
    @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : raise_exc
  task wait_wake;
    for (int n = 0; n < 8 && sleeping_o !== 1'b0; n++) @(negedge core_clk_i);
  endtask : wait_wake
  function automatic fault_sleep_pkg::fault_t fault_of(input int kind);
    if (kind == 9) return 13'h1800;
    if (kind == 10) return 13'h0400;
    if (kind == 11) return 13'h1000;
    if (kind == 12) return 13'h0600;
    return 13'h1 << kind;
  endfunction : fault_of
  function automatic logic locks(input fault_sleep_pkg::exec_ctx_t c, input int kind);
    return kind < 11 && (c == fault_sleep_pkg::CTX_NMI || c == fault_sleep_pkg::CTX_SEVERE);
  endfunction : locks
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge core_clk_i);
    bad_count++;
    wrap_up();
  end
  initial begin
    reset_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {fault_i, exc_i, cur_prio_i, priority_mask_bit_i, new_pending_i, debug_halt_i} = '0;
    {unstack_psr_err_i, unstack_main_sp_i, nmi_i, return_to_thread_i} = '0;
    {wait_interrupt_instr_i, wait_event_instr_i} = '0;
    ctx_i = fault_sleep_pkg::CTX_THREAD;
    seed = $urandom(4);
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    wb(1'b0, fault_sleep_pkg::SYS_CTRL_OFS, 32'h0);
    chk("sys_ctrl", rd, fault_sleep_pkg::SYS_CTRL_RST);
    wb(1'b0, fault_sleep_pkg::PWR_CTRL_OFS, 32'h0);
    chk("pwr_ctrl", rd, fault_sleep_pkg::PWR_CTRL_RST);
    wb(1'b1, 8'h0c, 32'hffff_ffff);
    wb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 30; i++) begin
      k = (i < 13) ? i : $urandom_range(12, 0);
      ctx = fault_sleep_pkg::exec_ctx_t'($urandom_range(3, 0));
      @(posedge core_clk_i);
      ctx_i <= ctx;
      fault_i <= fault_of(k);
      @(posedge core_clk_i);
      fault_i <= '0;
      @(negedge core_clk_i);
      chk("severe_take", severe_error_take_o, k < 11 && !locks(ctx, k));
      chk("locked", locked_o, locks(ctx, k));
      chk("halt", exec_halt_o, locks(ctx, k));
      if (locks(ctx, k)) fire(DBG);
      chk("debug_release", locked_o, 1'b0);
    end
    $display("test faults done");
    // unstack error lock and release paths
    ctx_i <= fault_sleep_pkg::CTX_NMI;
    {unstack_psr_err_i, unstack_main_sp_i} <= 2'b11;
    @(posedge core_clk_i);
    {unstack_psr_err_i, unstack_main_sp_i} <= 2'b00;
    @(negedge core_clk_i);
    chk("unstack_lock", locked_o, 1'b1);
    wb(1'b0, fault_sleep_pkg::STATUS_OFS, 32'h0);
    chk("status_nmi", rd, 32'h3);
    fire(NMI);
    chk("nmi_no_release", locked_o, 1'b1);
    fire(DBG);
    ctx_i <= fault_sleep_pkg::CTX_SEVERE;
    fault_i <= fault_of(4);
    @(posedge core_clk_i);
    fault_i <= '0;
    fire(NMI);
    chk("nmi_release", locked_o, 1'b0);
    chk("nmi_entry", exc_entry_o, 1'b1);
    $display("test lockup done");
    ctx_i <= fault_sleep_pkg::CTX_HANDLER;
    cur_prio_i <= 2'h1;
    fire(WAIT_INTERRUPT_INSTR);
    chk("wfi_sleep", sleeping_o & exec_halt_o, 1'b1);
    raise_exc(2'h2, 1'b1);
    raise_exc(2'h1, 1'b1);
    chk("low_prio", sleeping_o, 1'b1);
    raise_exc(2'h0, 1'b1);
    chk("high_prio", sleeping_o, 1'b0);
    raise_exc(2'h0, 1'b0);
    ctx_i <= fault_sleep_pkg::CTX_THREAD;
    priority_mask_bit_i <= 1'b1;
    fire(WAIT_INTERRUPT_INSTR);
    raise_exc(2'h3, 1'b1);
    chk("mask_wake", sleeping_o, 1'b0);
    repeat (3) @(negedge core_clk_i);
    chk("mask_hold", exc_entry_o, 1'b0);
    @(posedge core_clk_i);
    priority_mask_bit_i <= 1'b0;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("mask_clear", exc_entry_o, 1'b1);
    raise_exc(2'h0, 1'b0);
    $display("test wake priority done");
    for (int i = 0; i < 6; i++) begin
      {d, p} = (i < 4) ? 2'(i) : 2'($urandom_range(3, 0));
      wb(1'b1, fault_sleep_pkg::SYS_CTRL_OFS, {31'h0, d} << fault_sleep_pkg::DEEP_SEL_BIT);
      wb(1'b1, fault_sleep_pkg::PWR_CTRL_OFS, {31'h0, p} << fault_sleep_pkg::PWR_DOWN_BIT);
      fire(WAIT_INTERRUPT_INSTR);
      chk("deep", deep_sleep_o, d);
      chk("standby", standby_select_o, d & p);
      wb(1'b0, fault_sleep_pkg::STATUS_OFS, 32'h0);
      chk("status_sleep", rd, 32'h4 | ({31'h0, d} << fault_sleep_pkg::ST_DEEP_BIT));
      raise_exc(2'h0, 1'b1);
      chk("deep_wake", sleeping_o | deep_sleep_o, 1'b0);
      raise_exc(2'h0, 1'b0);
    end
    wb(1'b1, fault_sleep_pkg::SYS_CTRL_OFS, 32'h2);
    fire(RET);
    chk("return_sleep", sleeping_o, 1'b1);
    raise_exc(2'h0, 1'b1);
    raise_exc(2'h0, 1'b0);
    $display("test sleep levels done");
    fire(WAIT_EVENT_INSTR);
    chk("wfe_sleep", sleeping_o, 1'b1);
    ev.send(1'b0);
    wait_wake();
    chk("ext_wake", sleeping_o, 1'b0);
    ev.send(1'b0);
    repeat (6) @(negedge core_clk_i);
    fire(WAIT_EVENT_INSTR);
    chk("wfe_continue", {sleeping_o, wfe_continue_o}, 2'b01);
    fire(WAIT_EVENT_INSTR);
    chk("latch_cleared", sleeping_o, 1'b1);
    fire(NEWP);
    chk("pend_ignored", sleeping_o, 1'b1);
    ev.send(1'b1);
    wait_wake();
    chk("peer_wake", sleeping_o, 1'b0);
    wb(1'b1, fault_sleep_pkg::SYS_CTRL_OFS, 32'h10);
    fire(WAIT_EVENT_INSTR);
    fire(NEWP);
    chk("pend_wake", sleeping_o, 1'b0);
    fire(WAIT_EVENT_INSTR);
    raise_exc(2'h1, 1'b1);
    chk("wfe_exc_wake", sleeping_o, 1'b0);
    raise_exc(2'h0, 1'b0);
    $display("test events done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
